// ==== abl_backlight.sv ====
`timescale 1ns/100ps
// Functional notes
// - internal architecture: pin carries the adaptive duty from image content
// - backlight on bit switches the pwm output on or off
// - forced duty enable and 8-bit forced duty value configure forcing
// - forced enable set: forced value overrides any adaptive duty
// - adaptive duty keeps computing and is readable by the host
// - backlight off holds the pin at ground
// - adaptive mode select picks off, ui, still or moving
// - off mode: default gamma, duty 100% unless forced
// - still mode: gamma and duty both derived from content
// - moving mode: duty follows content, user gamma kept
// - adaptive processing runs only in normal display mode
// - dimming enable 0 applies levels at once, 1 ramps
// - ramp moves in equal-time steps, same shape up and down
// - moving uses moving step, others still step, both with step count
// - on=0 pol=0 rests low; on=1 pol=0 original polarity
// - on=1 pol=1 gives inverted pwm
// - mode codes: 0 off, 1 ui, 2 still, 3 moving
module abl_backlight #(
   parameter int DUTY_W = abl_pkg::ABL_DUTY_W,
   parameter int PWM_DIV = abl_pkg::ABL_PWM_DIV,
   parameter int DIM_UNIT = abl_pkg::ABL_DIM_UNIT
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire abl_pkg::abl_cfg_s CFG,
   input wire logic NORMAL_DISPLAY,
   input wire logic FRAME_DONE,
   input wire logic [DUTY_W-1:0] CONTENT_LEVEL,
   output logic BACKLIGHT_PWM_OUT,
   output logic [DUTY_W-1:0] DUTY_READBACK,
   output logic [1:0] GAMMA_SELECT,
   output logic DIMMING_ACTIVE
);
   // the ui mapping and the forced value are fixed at eight bits, so
   // any other duty width is refused at elaboration
   if (DUTY_W != 8 || DIM_UNIT < 1 || PWM_DIV < 1) begin : g_bad_param
      $error("abl_backlight: unsupported parameters");
   end

   // headroom above the ui floor; a content term beyond it saturates
   localparam logic [4:0] UI_ROOM =
      5'(abl_pkg::ABL_DUTY_FULL - abl_pkg::ABL_UI_BASE);

   typedef enum logic [1:0] {
      ABL_ST_IDLE = 2'b01,
      ABL_ST_RAMP = 2'b10
   } abl_state_e;

   abl_state_e state_r;
   logic [DUTY_W-1:0] adapt_r;
   logic [DUTY_W-1:0] target;
   logic [DUTY_W-1:0] level_r;
   logic [DUTY_W-1:0] tgt_r;
   logic [DUTY_W-1:0] inc;
   logic [$clog2(DIM_UNIT+1)-1:0] unit_r;
   logic [3:0] sub_r;
   logic [2:0] step_sel;
   logic step_tick;
   logic pwm_raw;

   // adaptive duty: content level mapped per mode, frozen outside normal
   // display. CONTENT_LEVEL stands in for the image statistics; the real
   // analysis would sit upstream and hand one value per frame.
   // the duty keeps its last value while the display leaves normal mode,
   // so the backlight does not jump when processing pauses
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         adapt_r <= abl_pkg::ABL_DUTY_RST;
      end else if (NORMAL_DISPLAY && FRAME_DONE) begin
         unique case (CFG.adaptive_mode_select)
            abl_pkg::ABL_MODE_OFF: adapt_r <= abl_pkg::ABL_DUTY_FULL;
            // ui keeps at most a mild reduction; the sum saturates, since
            // a bright frame would otherwise wrap to a near-black duty
            abl_pkg::ABL_MODE_UI: begin
               if (CONTENT_LEVEL[7:3] > UI_ROOM) begin
                  adapt_r <= abl_pkg::ABL_DUTY_FULL;
               end else begin
                  adapt_r <= abl_pkg::ABL_UI_BASE
                     + {3'h0, CONTENT_LEVEL[7:3]};
               end
            end
            abl_pkg::ABL_MODE_STILL: adapt_r <= CONTENT_LEVEL;
            abl_pkg::ABL_MODE_MOVING: adapt_r <= CONTENT_LEVEL;
         endcase
      end
   end

   // host readback of the computed duty, independent of forcing.
   // with the pin switched off the host drives the lamp itself and
   // reads this value to follow the content; it must keep updating
   // even while the pin is held at ground
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         DUTY_READBACK <= abl_pkg::ABL_DUTY_RST;
      end else begin
         DUTY_READBACK <= adapt_r;
      end
   end

   // gamma choice: off uses default set, still auto, moving/ui user set
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         GAMMA_SELECT <= 2'h0;
      end else begin
         GAMMA_SELECT <= CFG.adaptive_mode_select;
      end
   end

   // forced duty wins over any mode. forcing does not stop the adaptive
   // path: the readback above still follows content, so leaving the
   // forced state resumes at a current level rather than a stale one
   assign target = CFG.forced_duty_enable ? CFG.forced_duty_value
                                          : adapt_r;

   // step size per mode; shared by up and down ramps
   assign step_sel = (CFG.adaptive_mode_select == abl_pkg::ABL_MODE_MOVING)
                     ? CFG.moving_dim_step : CFG.still_dim_step;
   // a step of n moves the level 2^n codes per tick, capped at the gap
   assign inc = DUTY_W'(1) << step_sel;

   // time base: each step lasts dim_step_count+1 base units.
   // the counters rest at zero while idle, so the first step of every
   // ramp takes a full interval and the ramp shape does not depend on
   // when the new target arrived.
   // limitation: a step count changed mid-ramp takes effect at once and
   // may stretch the current step by up to one full wrap of sub_r
   always_ff @(posedge SYS_CLK) begin
      if (RST || state_r == ABL_ST_IDLE) begin
         unit_r <= '0;
         sub_r <= '0;
      end else if (unit_r == ($clog2(DIM_UNIT+1))'(DIM_UNIT - 1)) begin
         unit_r <= '0;
         sub_r <= (sub_r == CFG.dim_step_count) ? 4'h0 : sub_r + 4'h1;
      end else begin
         unit_r <= unit_r + 1'b1;
      end
   end
   assign step_tick = (state_r == ABL_ST_RAMP) && (sub_r == CFG.dim_step_count)
      && (unit_r == ($clog2(DIM_UNIT+1))'(DIM_UNIT - 1));

   // dimming state machine and output level.
   // idle: level equals target; a new target starts a ramp next cycle.
   // ramp: the level moves one increment per step tick, clamped to the
   // target, so up and down ramps have the same shape.
   // dimming off snaps the level to the target, which also aborts any
   // ramp in flight; this trades smoothness for an immediate response.
   // tgt_r lags target by one cycle so the compare below never sees a
   // half-updated forced value
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_r <= ABL_ST_IDLE;
         level_r <= abl_pkg::ABL_DUTY_RST;
         tgt_r <= abl_pkg::ABL_DUTY_RST;
      end else if (!CFG.dimming_enable_bit) begin
         state_r <= ABL_ST_IDLE;
         level_r <= target;
         tgt_r <= target;
      end else begin
         tgt_r <= target;
         unique case (state_r)
            ABL_ST_IDLE: begin
               if (target != level_r) state_r <= ABL_ST_RAMP;
            end
            ABL_ST_RAMP: begin
               // level_r is never reloaded on retarget, so the ramp
               // continues from where it stands
               if (tgt_r == level_r) begin
                  state_r <= ABL_ST_IDLE;
               end else if (step_tick) begin
                  if (tgt_r > level_r)
                     level_r <= (tgt_r - level_r > inc) ? level_r + inc : tgt_r;
                  else
                     level_r <= (level_r - tgt_r > inc) ? level_r - inc : tgt_r;
               end
            end
         endcase
      end
   end

   // ramp status for the host; lags the state by one cycle because the
   // output must come straight from a flip-flop
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         DIMMING_ACTIVE <= 1'b0;
      end else begin
         DIMMING_ACTIVE <= (state_r == ABL_ST_RAMP);
      end
   end

   // carrier: the ramped level only reaches the pin at a period end, so
   // up to one period of latency is added to every brightness change
   abl_pwm_core #(
      .DUTY_W(DUTY_W),
      .DIV(PWM_DIV)
   ) u_pwm (
      .clk(SYS_CLK),
      .rst(RST),
      .duty(level_r),
      .pwm(pwm_raw)
   );

   // pin: off holds ground; on passes pwm, inverted when polarity set.
   // off wins over polarity so a host-driven lamp never sees a level
   always_ff @(posedge SYS_CLK) begin
      if (RST || !CFG.backlight_on_bit) begin
         BACKLIGHT_PWM_OUT <= 1'b0;
      end else begin
         BACKLIGHT_PWM_OUT <= pwm_raw ^ CFG.pwm_polarity_bit;
      end
   end
endmodule : abl_backlight

// ==== abl_pkg.sv ====
package abl_pkg;
   // adaptive mode encoding
   typedef enum logic [1:0] {
      ABL_MODE_OFF = 2'h0,
      ABL_MODE_UI = 2'h1,
      ABL_MODE_STILL = 2'h2,
      ABL_MODE_MOVING = 2'h3
   } abl_mode_e;

   // configuration bits carried together into the core
   typedef struct packed {
      logic backlight_on_bit;
      logic pwm_polarity_bit;
      logic dimming_enable_bit;
      logic forced_duty_enable;
      logic [7:0] forced_duty_value;
      abl_mode_e adaptive_mode_select;
      logic [2:0] still_dim_step;
      logic [2:0] moving_dim_step;
      logic [3:0] dim_step_count;
   } abl_cfg_s;

   localparam int ABL_DUTY_W = 8;
   localparam logic [7:0] ABL_DUTY_FULL = 8'hFF;
   localparam logic [7:0] ABL_DUTY_RST = 8'hFF;
   // ui mode floor: the duty never drops below this level in ui mode
   localparam logic [7:0] ABL_UI_BASE = 8'hE6;
   // pwm carrier prescale: one count enable every this many clocks
   localparam int ABL_PWM_DIV = 4;
   // base ramp tick: one dimming time unit in clocks
   localparam int ABL_DIM_UNIT = 256;
endpackage : abl_pkg

// ==== abl_pwm_core.sv ====
`timescale 1ns/100ps
// free-running pwm carrier; duty latched at period start to avoid glitches
module abl_pwm_core #(
   parameter int DUTY_W = 8,
   parameter int DIV = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [DUTY_W-1:0] duty,
   output logic pwm
);
   // refuse a prescale or width the counters cannot serve
   if (DIV < 1 || DUTY_W < 2) begin : g_bad_param
      $error("abl_pwm_core: bad parameters");
   end

   logic [$clog2(DIV+1)-1:0] div_r;
   logic tick;
   logic [DUTY_W-1:0] cnt_r;
   logic [DUTY_W-1:0] duty_r;
   logic full;

   assign tick = (div_r == '0);
   // all-ones duty means fully on, no one-slot gap per period
   assign full = &duty_r;

   // prescaler
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         div_r <= ($clog2(DIV+1))'(DIV - 1);
      end else begin
         div_r <= div_r - 1'b1;
      end
   end

   // period counter and duty latch
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         duty_r <= '0;
      end else if (tick) begin
         cnt_r <= cnt_r + 1'b1;
         if (&cnt_r) begin
            duty_r <= duty;
         end
      end
   end

   // compare
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm <= 1'b0;
      end else begin
         pwm <= full || (cnt_r < duty_r);
      end
   end
endmodule : abl_pwm_core

// ==== abl_led_drv.sv ====
`timescale 1ns/100ps
// lamp driver stand-in: integrates the on-time of the pin
module abl_led_drv (
   input wire logic clk,
   input wire logic pwm,
   input wire logic clr,
   output int on_cnt
);
   // perceived brightness is the share of high samples
   always_ff @(posedge clk) begin
      on_cnt <= clr ? 0 : on_cnt + int'(pwm);
   end
endmodule : abl_led_drv

// ==== abl_backlight_checker.sv ====
`timescale 1ns/100ps
module abl_backlight_checker #(
   parameter int DUTY_W = 8
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire abl_pkg::abl_cfg_s CFG,
   input wire logic NORMAL_DISPLAY,
   input wire logic FRAME_DONE,
   input wire logic [DUTY_W-1:0] CONTENT_LEVEL,
   input wire logic BACKLIGHT_PWM_OUT,
   input wire logic [DUTY_W-1:0] DUTY_READBACK,
   input wire logic [1:0] GAMMA_SELECT,
   input wire logic DIMMING_ACTIVE
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // a sample is taken only in normal display
   sequence take_s;
      FRAME_DONE && NORMAL_DISPLAY;
   endsequence
   sequence off2_s;
      !CFG.backlight_on_bit ##1 !CFG.backlight_on_bit;
   endsequence
   pin_ground_a: assert property (off2_s |-> !BACKLIGHT_PWM_OUT)
      else $error("pin high with backlight off");
   rb_hold_a: assert property ($changed(DUTY_READBACK) |->
      $past(FRAME_DONE, 2) && $past(NORMAL_DISPLAY, 2))
      else $error("readback moved without a frame");
   rb_value_a: assert property (take_s ##0 CFG.adaptive_mode_select[1]
      |-> ##2 DUTY_READBACK == $past(CONTENT_LEVEL, 2))
      else $error("readback not content");
   gamma_mode_a: assert property (NORMAL_DISPLAY ##1 (NORMAL_DISPLAY &&
      $stable(CFG.adaptive_mode_select))
      |-> GAMMA_SELECT == CFG.adaptive_mode_select)
      else $error("gamma not mode");
   dim_idle_a: assert property (!CFG.dimming_enable_bit [*3]
      |-> !DIMMING_ACTIVE) else $error("ramp with dimming off");
   dim_start_a: assert property (CFG.dimming_enable_bit &&
      $stable(CFG.forced_duty_enable) && CFG.forced_duty_enable &&
      $changed(CFG.forced_duty_value) && !DIMMING_ACTIVE
      |-> ##[1:2] DIMMING_ACTIVE) else $error("no ramp on new level");
   dim_step_a: assert property ($rose(DIMMING_ACTIVE)
      |-> DIMMING_ACTIVE [*3]) else $error("ramp too short");
   rst_vals_a: assert property ($fell(RST) |-> !BACKLIGHT_PWM_OUT &&
      DUTY_READBACK == 8'hFF && GAMMA_SELECT == 2'h0 && !DIMMING_ACTIVE)
      else $error("bad reset values");
endmodule : abl_backlight_checker
bind abl_backlight abl_backlight_checker #(.DUTY_W(DUTY_W)) chk_i (
   .SYS_CLK, .RST, .CFG, .NORMAL_DISPLAY, .FRAME_DONE, .CONTENT_LEVEL,
   .BACKLIGHT_PWM_OUT, .DUTY_READBACK, .GAMMA_SELECT, .DIMMING_ACTIVE);

// ==== test_adaptive_backlight_pwm.sv ====
`timescale 1ns/100ps
module test_adaptive_backlight_pwm;
   logic SYS_CLK = 0;
   logic RST = 1;
   abl_pkg::abl_cfg_s cfg = '0;
   logic nd = 1;
   logic fd = 0;
   logic clr = 0;
   logic [7:0] lvl = 8'h00;
   logic pwm, dim;
   logic [7:0] rb;
   logic [1:0] gam;
   int on_cnt, fails = 0, cmp_count = 0;
   // short pwm prescale and ramp unit keep the run brief
   abl_backlight #(.PWM_DIV(1), .DIM_UNIT(4)) dut (.SYS_CLK, .RST,
      .CFG(cfg), .NORMAL_DISPLAY(nd), .FRAME_DONE(fd),
      .CONTENT_LEVEL(lvl), .BACKLIGHT_PWM_OUT(pwm),
      .DUTY_READBACK(rb), .GAMMA_SELECT(gam), .DIMMING_ACTIVE(dim));
   abl_led_drv led (.clk(SYS_CLK), .pwm, .clr, .on_cnt);
   initial forever #5 SYS_CLK = ~SYS_CLK;
   task tick(input int n);
      repeat (n) @(posedge SYS_CLK) #1;
   endtask : tick
   task chk(input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // wait past a period end so the duty is latched, then integrate
   task meas(input logic [8:0] exp);
      tick(600);
      clr = 1;
      tick(1);
      clr = 0;
      tick(256);
      chk(on_cnt[8:0], exp);
   endtask : meas
   task frame(input logic [7:0] c);
      lvl = c;
      fd = 1;
      tick(1);
      fd = 0;
      tick(3);
   endtask : frame
   task t_pin;
      meas(9'h000);
      cfg.backlight_on_bit = 1;
      meas(9'h100);
      cfg.pwm_polarity_bit = 1;
      meas(9'h000);
      cfg.backlight_on_bit = 0;
      meas(9'h000);
      cfg.pwm_polarity_bit = 0;
      cfg.backlight_on_bit = 1;
      $display("pin test done");
   endtask : t_pin
   task t_modes;
      logic [7:0] e [4];
      e = '{8'hFF, 8'hF6, 8'h80, 8'h80};
      for (int m = 0; m < 4; m++) begin
         cfg.adaptive_mode_select = abl_pkg::abl_mode_e'(m);
         frame(8'h80);
         chk(gam, m[1:0]);
         chk(rb, e[m]);
      end
      // a bright ui frame must saturate, not wrap
      cfg.adaptive_mode_select = abl_pkg::ABL_MODE_UI;
      frame(8'hFF);
      chk(rb, 8'hFF);
      cfg.adaptive_mode_select = abl_pkg::ABL_MODE_MOVING;
      frame(8'h80);
      meas(9'h080);
      nd = 0;
      frame(8'h11);
      chk(rb, 8'h80);
      nd = 1;
      $display("mode test done");
   endtask : t_modes
   task t_force;
      cfg.forced_duty_enable = 1;
      cfg.forced_duty_value = 8'h40;
      meas(9'h040);
      frame(8'h22);
      chk(rb, 8'h22);
      $display("force test done");
   endtask : t_force
   task t_dim;
      int n;
      cfg.dimming_enable_bit = 1;
      cfg.moving_dim_step = 3'h3;
      for (int k = 0; k < 2; k++) begin
         cfg.forced_duty_value = k ? 8'h40 : 8'h60;
         tick(3);
         n = 0;
         while (dim === 1'b1 && n < 400) begin
            tick(1);
            n++;
         end
         chk(9'(n > 9 && n < 22), 9'h001);
         if (n >= 400) test_done;
      end
      // retarget mid-ramp: the level keeps moving from where it stands
      cfg.forced_duty_value = 8'h80;
      tick(6);
      chk(dim, 1'b1);
      cfg.forced_duty_value = 8'h70;
      n = 0;
      while (dim === 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      chk(9'(n > 4 && n < 400), 9'h001);
      if (n >= 400) test_done;
      meas(9'h070);
      cfg.dimming_enable_bit = 0;
      cfg.forced_duty_value = 8'h10;
      tick(2);
      chk(dim, 1'b0);
      meas(9'h010);
      $display("dimming test done");
   endtask : t_dim
   task test_done;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      tick(16);
      RST = 0;
      tick(2);
      t_pin;
      t_modes;
      t_force;
      t_dim;
      test_done;
   end
endmodule : test_adaptive_backlight_pwm
